// [pkg/dfd_pkg.sv]
// package: constants, types and carriers of the drive fault diagnostics
// Overview of operation
// (RULE_01) standard view: green flashes 1 Hz when holding, 2 Hz when travelling
// (RULE_02) link on: fast red if bad, steady green if good; off and good: slow red/green
// (RULE_03) can view green: 1 Hz stopped, fast pre-operational, steady operational
// (RULE_04) can view red flashes 1 Hz when error counter exceeds 96
// (RULE_05) can view red off without error, steady on in bus-off
// (RULE_06) operating condition and error condition shown together on separate colours
// (RULE_07) every effective fault that aborts a travel becomes a new log entry
// (RULE_08) log holds 64 entries, a new fault overwrites the oldest when full
// (RULE_09) opening shows newest; up steps to older entry, down to newer entry
// (RULE_10) entry keeps error, condition, travel, consecutive count, direction, hours, temp, current, position
// (RULE_11) date and time stored only in canopen lift or link operation
// (RULE_12) log clear empties log and zeroes the three abort and mains counters
// (RULE_13) error number in masks 1-5 suppresses that error if it is maskable
// (RULE_14) default-inactive error becomes active when entered in negative mask
// (RULE_15) block counter counts consecutive lockable faults, zero after fault-free travel
// (RULE_16) timed-drop mode drops malfunction output 2 s with speed presets removed
// (RULE_17) lock modes hold malfunction output dropped after 3rd, 2nd or 1st fault
// (RULE_18) note 077 when newest error repeated more than 5 times in succession
// (RULE_19) note 080 on evacuation to normal, note 081 on normal to evacuation
// (RULE_20) note 010 after software update; note 000 marks an empty log
// (RULE_21) error clears 2 s after cause gone with no travel inputs; travel restarts; here errors of NO_AUTO_ACK_MIN (900) and up never clear
// (RULE_22) scrolling stops at newest and oldest entries, no wrap
package dfd_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int ACK_TIME_MS = 2000;
  localparam int DROP_TIME_MS = 2000;
  localparam int BLINK_TICK_US = 62500;
  localparam int ACK_CYCLES = CLK_HZ / 1000 * ACK_TIME_MS;
  localparam int DROP_CYCLES = CLK_HZ / 1000 * DROP_TIME_MS;
  localparam int BLINK_TICK_CYCLES = CLK_HZ / 1_000_000 * BLINK_TICK_US;
  localparam int LOG_DEPTH = 64;
  localparam int NUM_ERR_MASKS = 5;
  localparam int PHASE_W = 5;
  localparam int PH_FAST = 0;
  localparam int PH_TWICE = 2;
  localparam int PH_ONCE = 3;
  localparam int PH_SLOW = 4;
  localparam int ERR_W = 10;
  localparam int CNT_W = 16;
  localparam int CONSEC_W = 8;
  localparam logic [7:0] CAN_WARN_LIMIT = 8'h60;
  localparam logic [ERR_W-1:0] NOTE_EMPTY = 10'h000;
  localparam logic [ERR_W-1:0] NOTE_SW_UPDATE = 10'h00A;
  localparam logic [ERR_W-1:0] NOTE_REPEATED = 10'h04D;
  localparam logic [ERR_W-1:0] NOTE_EVA_TO_NORM = 10'h050;
  localparam logic [ERR_W-1:0] NOTE_NORM_TO_EVA = 10'h051;
  localparam logic [ERR_W-1:0] NO_AUTO_ACK_MIN = 10'h384;
  localparam logic [CONSEC_W-1:0] CONSEC_NOTE_LIMIT = 8'h05;
  localparam logic [1:0] LOCK_N3 = 2'h3;
  localparam logic [1:0] LOCK_N2 = 2'h2;
  localparam logic [1:0] LOCK_N1 = 2'h1;
  localparam logic MALF_OUT_RST = 1'b1;

  typedef enum logic [3:0] {
    BLK_FIX_2S = 4'h1,
    BLK_LOCK_3 = 4'h2,
    BLK_LOCK_2 = 4'h4,
    BLK_LOCK_1 = 4'h8
  } dfd_block_mode_t;

  typedef enum logic [2:0] {
    VIEW_STANDARD = 3'h1,
    VIEW_LINK = 3'h2,
    VIEW_CAN = 3'h4
  } dfd_led_view_t;

  typedef enum logic [2:0] {
    CAN_STOPPED = 3'h1,
    CAN_PREOP = 3'h2,
    CAN_OPERATIONAL = 3'h4
  } dfd_can_state_t;

  typedef enum logic [2:0] {
    ERR_IDLE = 3'h1,
    ERR_ACTIVE = 3'h2,
    ERR_ACK_WAIT = 3'h4
  } dfd_err_state_t;

  typedef struct packed {
    logic slow;
    logic once;
    logic twice;
    logic fast;
  } dfd_blink_t;

  typedef struct packed {
    logic maskable;
    logic default_off;
    logic lockable;
  } dfd_attr_t;

  typedef struct packed {
    logic [ERR_W-1:0] err_no;
    logic [9:0] op_cond;
    logic [23:0] travel_no;
    logic dir_up;
    logic [15:0] op_hours;
    logic [7:0] stage_temp;
    logic [7:0] motor_current;
    logic [15:0] car_pos;
    logic [31:0] date_time;
  } dfd_fault_t;

  typedef struct packed {
    dfd_fault_t rec;
    logic [CONSEC_W-1:0] consec;
  } dfd_entry_t;
endpackage

// [logic/dfd_blink.sv]
// flash phase generator for the status led
`timescale 1ns/1ps
module dfd_blink import dfd_pkg::*; #(
  parameter int TICK_CYC = BLINK_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  output dfd_blink_t blink_ph
);
  localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  if (TICK_CYC < 2) begin : g_chk
    $error("dfd_blink: TICK_CYC must be at least 2");
  end

  logic [TW-1:0] tick_cnt_ff;
  logic [PHASE_W-1:0] phase_ff;
  dfd_blink_t blink_ff;
  logic tick_wrap;

  assign tick_wrap = (tick_cnt_ff == TW'(TICK_CYC - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= '0;
    end else if (tick_wrap) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= '0;
    end else if (tick_wrap) begin
      phase_ff <= phase_ff + 1'b1;
    end
  end

  // 8 Hz, 2 Hz, 1 Hz and 0.5 Hz square waves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_ff <= '0;
    end else begin
      blink_ff.fast <= phase_ff[PH_FAST];
      blink_ff.twice <= phase_ff[PH_TWICE];
      blink_ff.once <= phase_ff[PH_ONCE];
      blink_ff.slow <= phase_ff[PH_SLOW];
    end
  end

  assign blink_ph = blink_ff;

  a_phase_step: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE_01)
    tick_wrap |=> phase_ff == $past(phase_ff) + 1'b1)
    else $error("flash phase did not advance on tick");
endmodule

// [logic/dfd_top.sv]
// drive fault diagnostics: led, fault log, masks, block counter, notes
`timescale 1ns/1ps
module dfd_top import dfd_pkg::*; #(
  parameter int ACK_CYC = ACK_CYCLES,
  parameter int DROP_CYC = DROP_CYCLES,
  parameter int TICK_CYC = BLINK_TICK_CYCLES,
  parameter int LOG_DEPTH_P = LOG_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input dfd_led_view_t led_view,
  input wire logic drive_travel,
  input wire logic link_enabled,
  input wire logic link_ok,
  input dfd_can_state_t can_state,
  input wire logic [7:0] can_err_count,
  input wire logic can_busoff,
  input wire logic fault_evt,
  input dfd_fault_t fault_rec,
  input dfd_attr_t fault_attr,
  input wire logic fault_cause_present,
  input wire logic [NUM_ERR_MASKS-1:0][ERR_W-1:0] err_mask,
  input wire logic [ERR_W-1:0] neg_err_mask,
  input wire logic datetime_mode,
  input wire logic speed_preset_any,
  input wire logic travel_done,
  input dfd_block_mode_t block_mode_select,
  input wire logic fault_log_clear,
  input wire logic log_open,
  input wire logic scroll_up,
  input wire logic scroll_down,
  input wire logic mains_interrupt_evt,
  input wire logic enable_loss_abort_evt,
  input wire logic contactor_abort_evt,
  input wire logic evac_mode,
  input wire logic sw_update_done,
  output logic led_red,
  output logic led_green,
  output logic malfunction_output,
  output logic error_active,
  output logic locked,
  output dfd_entry_t view_entry,
  output logic [$clog2(LOG_DEPTH_P)-1:0] view_ofs,
  output logic [$clog2(LOG_DEPTH_P+1)-1:0] log_count,
  output logic [CNT_W-1:0] mains_interrupt_count,
  output logic [CNT_W-1:0] enable_loss_abort_count,
  output logic [CNT_W-1:0] contactor_abort_count,
  output logic note_stb,
  output logic [ERR_W-1:0] note_code
);
  localparam int PW = $clog2(LOG_DEPTH_P);
  localparam int CW = $clog2(LOG_DEPTH_P + 1);
  localparam int AKW = $clog2(ACK_CYC);
  localparam int DRW = $clog2(DROP_CYC);

  if (LOG_DEPTH_P < 2 || ACK_CYC < 2 || DROP_CYC < 2) begin : g_chk
    $error("dfd_top: depth and timer counts must be at least 2");
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  dfd_blink_t blink_ph;

  dfd_blink #(
    .TICK_CYC(TICK_CYC)
  ) u_blink (
    .clk(clk),
    .rst_b(rst_b),
    .blink_ph(blink_ph)
  );

  // led colours are composed independently so both can show at once
  logic led_red_ff;
  logic led_green_ff;
  logic nxt_red;
  logic nxt_green;

  always_comb begin
    nxt_red = 1'b0;
    nxt_green = 1'b0;
    if (led_view == VIEW_STANDARD) begin
      nxt_green = drive_travel ? blink_ph.twice : blink_ph.once; // see (RULE_01)
    end else if (led_view == VIEW_LINK) begin
      if (link_enabled) begin
        nxt_red = !link_ok && blink_ph.fast; // see (RULE_02)
        nxt_green = link_ok;
      end else if (link_ok) begin
        nxt_red = blink_ph.slow;
        nxt_green = !blink_ph.slow;
      end
    end else if (led_view == VIEW_CAN) begin
      case (can_state) // see (RULE_03)
        CAN_STOPPED: nxt_green = blink_ph.once;
        CAN_PREOP: nxt_green = blink_ph.fast;
        CAN_OPERATIONAL: nxt_green = 1'b1;
        default: nxt_green = 1'b0;
      endcase
      if (can_busoff) begin
        nxt_red = 1'b1; // see (RULE_05)
      end else if (can_err_count > CAN_WARN_LIMIT) begin
        nxt_red = blink_ph.once; // see (RULE_04)
      end // red and green driven separately, see (RULE_06)
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_red_ff <= 1'b0;
      led_green_ff <= 1'b0;
    end else begin
      led_red_ff <= nxt_red;
      led_green_ff <= nxt_green;
    end
  end

  // fault qualification by masks
  logic [NUM_ERR_MASKS-1:0] mask_hit;
  logic eff_fault;

  for (genvar gi = 0; gi < NUM_ERR_MASKS; gi++) begin : g_mask
    assign mask_hit[gi] = (err_mask[gi] == fault_rec.err_no);
  end

  assign eff_fault = fault_evt
    && (!fault_attr.default_off || neg_err_mask == fault_rec.err_no) // see (RULE_14)
    && !(fault_attr.maskable && |mask_hit); // see (RULE_13)

  // fault log ring
  dfd_entry_t log_mem [LOG_DEPTH_P];
  logic [PW-1:0] wr_ptr_ff;
  logic [CW-1:0] count_ff;
  logic [PW-1:0] ofs_ff;
  logic [ERR_W-1:0] last_err_ff;
  logic [CONSEC_W-1:0] consec_ff;
  logic [CONSEC_W-1:0] nxt_consec;
  logic [PW-1:0] wr_idx;
  logic [PW:0] rd_sum;
  logic [PW-1:0] rd_idx;
  dfd_entry_t new_entry;
  dfd_entry_t view_ff;

  assign wr_idx = fault_log_clear ? '0 : wr_ptr_ff;

  always_comb begin
    nxt_consec = 8'h01;
    if (count_ff != '0 && !fault_log_clear && fault_rec.err_no == last_err_ff) begin
      nxt_consec = (consec_ff == 8'hFF) ? consec_ff : consec_ff + 1'b1;
    end
  end

  always_comb begin
    new_entry.rec = fault_rec; // see (RULE_10)
    new_entry.consec = nxt_consec;
    if (!datetime_mode) begin
      new_entry.rec.date_time = '0; // see (RULE_11)
    end
  end

  always_ff @(posedge clk) begin
    if (eff_fault) begin
      log_mem[wr_idx] <= new_entry; // see (RULE_07)
    end
  end

  // the fault is stored after a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      count_ff <= '0;
    end else if (eff_fault) begin
      wr_ptr_ff <= (wr_idx == PW'(LOG_DEPTH_P - 1)) ? '0 : wr_idx + 1'b1; // see (RULE_08)
      if (fault_log_clear) begin
        count_ff <= CW'(1);
      end else if (count_ff != CW'(LOG_DEPTH_P)) begin
        count_ff <= count_ff + 1'b1;
      end
    end else if (fault_log_clear) begin
      wr_ptr_ff <= '0; // see (RULE_12)
      count_ff <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_err_ff <= '0;
      consec_ff <= '0;
    end else if (eff_fault) begin
      last_err_ff <= fault_rec.err_no;
      consec_ff <= nxt_consec;
    end
  end

  // offset back from newest; stops at both ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ofs_ff <= '0;
    end else if (log_open || fault_log_clear) begin
      ofs_ff <= '0; // see (RULE_09)
    end else if (scroll_up && !scroll_down && CW'(ofs_ff) + 1'b1 < count_ff) begin
      ofs_ff <= ofs_ff + 1'b1; // see (RULE_22)
    end else if (scroll_down && !scroll_up && ofs_ff != '0) begin
      ofs_ff <= ofs_ff - 1'b1;
    end
  end

  assign rd_sum = {1'b0, wr_ptr_ff} + (PW + 1)'(LOG_DEPTH_P - 1) - {1'b0, ofs_ff};
  assign rd_idx = (rd_sum >= (PW + 1)'(LOG_DEPTH_P)) ? PW'(rd_sum - (PW + 1)'(LOG_DEPTH_P)) : PW'(rd_sum);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      view_ff <= '0;
    end else if (count_ff == '0) begin
      view_ff <= '0;
      view_ff.rec.err_no <= NOTE_EMPTY; // see (RULE_20)
    end else begin
      view_ff <= log_mem[rd_idx];
    end
  end

  // statistics counters; an event in the clear cycle survives as one
  logic [CNT_W-1:0] stat_ff [3];
  logic [2:0] stat_evt;

  assign stat_evt = {contactor_abort_evt, enable_loss_abort_evt, mains_interrupt_evt};

  for (genvar gs = 0; gs < 3; gs++) begin : g_stat
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        stat_ff[gs] <= '0;
      end else if (stat_evt[gs]) begin
        stat_ff[gs] <= fault_log_clear ? CNT_W'(1) : (&stat_ff[gs] ? stat_ff[gs] : stat_ff[gs] + 1'b1);
      end else if (fault_log_clear) begin
        stat_ff[gs] <= '0; // see (RULE_12)
      end
    end
  end

  // block counter and lock
  logic [1:0] blk_cnt_ff;
  logic [1:0] nxt_blk;
  logic [1:0] lock_thr;
  logic lock_mode;
  logic travel_fault_ff;
  logic locked_ff;

  assign lock_mode = (block_mode_select != BLK_FIX_2S);
  assign nxt_blk = (blk_cnt_ff == 2'h3) ? blk_cnt_ff : blk_cnt_ff + 1'b1;

  always_comb begin
    case (block_mode_select)
      BLK_LOCK_3: lock_thr = LOCK_N3;
      BLK_LOCK_2: lock_thr = LOCK_N2;
      BLK_LOCK_1: lock_thr = LOCK_N1;
      default: lock_thr = LOCK_N3;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      travel_fault_ff <= 1'b0;
    end else if (eff_fault) begin
      travel_fault_ff <= 1'b1;
    end else if (travel_done) begin
      travel_fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_cnt_ff <= '0;
    end else if (eff_fault && fault_attr.lockable) begin
      blk_cnt_ff <= nxt_blk; // see (RULE_15)
    end else if (travel_done && !travel_fault_ff && !eff_fault) begin
      blk_cnt_ff <= '0;
    end
  end

  // lock is left only by reset, as a power cycle would
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      locked_ff <= 1'b0;
    end else if (eff_fault && fault_attr.lockable && lock_mode && nxt_blk >= lock_thr) begin
      locked_ff <= 1'b1; // see (RULE_17)
    end
  end

  // error acknowledge machine
  dfd_err_state_t err_st_ff;
  logic [AKW-1:0] ack_cnt_ff;
  logic [ERR_W-1:0] cur_err_ff;
  logic err_act_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_st_ff <= ERR_IDLE;
      ack_cnt_ff <= '0;
      cur_err_ff <= '0;
      err_act_ff <= 1'b0;
    end else if (eff_fault) begin
      err_st_ff <= ERR_ACTIVE;
      err_act_ff <= 1'b1;
      ack_cnt_ff <= '0;
      cur_err_ff <= fault_rec.err_no;
    end else begin
      case (err_st_ff)
        ERR_ACTIVE: begin
          if (!fault_cause_present && !speed_preset_any && cur_err_ff < NO_AUTO_ACK_MIN) begin
            err_st_ff <= ERR_ACK_WAIT;
            ack_cnt_ff <= '0;
          end
        end
        ERR_ACK_WAIT: begin
          if (fault_cause_present || speed_preset_any) begin
            err_st_ff <= ERR_ACTIVE; // see (RULE_21)
          end else if (ack_cnt_ff == AKW'(ACK_CYC - 1)) begin
            err_st_ff <= ERR_IDLE;
            err_act_ff <= 1'b0;
          end else begin
            ack_cnt_ff <= ack_cnt_ff + 1'b1;
          end
        end
        default: err_st_ff <= ERR_IDLE;
      endcase
    end
  end

  // timed drop of the malfunction output
  logic drop_ff;
  logic [DRW-1:0] drop_cnt_ff;
  logic malf_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_ff <= 1'b0;
      drop_cnt_ff <= '0;
    end else if (eff_fault) begin
      drop_ff <= 1'b1;
      drop_cnt_ff <= '0;
    end else if (drop_ff && speed_preset_any) begin
      drop_cnt_ff <= '0; // see (RULE_16)
    end else if (drop_ff && drop_cnt_ff == DRW'(DROP_CYC - 1)) begin
      drop_ff <= 1'b0;
    end else if (drop_ff) begin
      drop_cnt_ff <= drop_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      malf_ff <= MALF_OUT_RST;
    end else if (lock_mode) begin
      malf_ff <= !locked_ff && err_st_ff == ERR_IDLE;
    end else begin
      malf_ff <= !drop_ff;
    end
  end

  // informational notes, one per cycle by priority
  logic evac_prev_ff;
  logic note_stb_ff;
  logic [ERR_W-1:0] note_code_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evac_prev_ff <= 1'b0;
      note_stb_ff <= 1'b0;
      note_code_ff <= NOTE_EMPTY;
    end else begin
      evac_prev_ff <= evac_mode;
      note_stb_ff <= 1'b1;
      if (eff_fault && nxt_consec > CONSEC_NOTE_LIMIT) begin
        note_code_ff <= NOTE_REPEATED; // see (RULE_18)
      end else if (evac_mode && !evac_prev_ff) begin
        note_code_ff <= NOTE_NORM_TO_EVA; // see (RULE_19)
      end else if (!evac_mode && evac_prev_ff) begin
        note_code_ff <= NOTE_EVA_TO_NORM;
      end else if (sw_update_done) begin
        note_code_ff <= NOTE_SW_UPDATE; // see (RULE_20)
      end else begin
        note_stb_ff <= 1'b0;
      end
    end
  end

  assign led_red = led_red_ff;
  assign led_green = led_green_ff;
  assign malfunction_output = malf_ff;
  assign error_active = err_act_ff;
  assign locked = locked_ff;
  assign view_entry = view_ff;
  assign view_ofs = ofs_ff;
  assign log_count = count_ff;
  assign mains_interrupt_count = stat_ff[0];
  assign enable_loss_abort_count = stat_ff[1];
  assign contactor_abort_count = stat_ff[2];
  assign note_stb = note_stb_ff;
  assign note_code = note_code_ff;

  sequence s_fix_fault;
    !lock_mode && eff_fault;
  endsequence

  sequence s_dropped;
    drop_ff ##1 !malf_ff;
  endsequence

  a_travel_blink: assert property (led_view == VIEW_STANDARD && drive_travel // see (RULE_01)
    |=> led_green_ff == $past(blink_ph.twice) && !led_red_ff)
    else $error("travel flash wrong");
  a_link_bad: assert property (led_view == VIEW_LINK && link_enabled && !link_ok // see (RULE_02)
    |=> !led_green_ff && led_red_ff == $past(blink_ph.fast))
    else $error("bad link not fast red");
  a_can_oper: assert property (led_view == VIEW_CAN && can_state == CAN_OPERATIONAL |=> led_green_ff) // see (RULE_03)
    else $error("operational not steady green");
  a_can_warn: assert property (led_view == VIEW_CAN && !can_busoff && can_err_count > 8'h60 // see (RULE_04)
    |=> led_red_ff == $past(blink_ph.once))
    else $error("warning flash wrong");
  a_can_busoff: assert property (led_view == VIEW_CAN && can_busoff |=> led_red_ff) // see (RULE_05)
    else $error("bus-off not steady red");
  a_log_grow: assert property (eff_fault && !fault_log_clear && count_ff < CW'(LOG_DEPTH_P) // see (RULE_07)
    |=> count_ff == $past(count_ff) + 1'b1)
    else $error("fault not logged");
  a_log_cap: assert property (count_ff <= CW'(LOG_DEPTH_P)) // see (RULE_08)
    else $error("log count over depth");
  a_open_newest: assert property (log_open |=> ofs_ff == '0) // see (RULE_09)
    else $error("open not at newest");
  a_log_clear: assert property (fault_log_clear && !eff_fault && !mains_interrupt_evt // see (RULE_12)
    |=> count_ff == '0 && stat_ff[0] == '0)
    else $error("clear failed");
  a_mask_drop: assert property (fault_evt && fault_attr.maskable && |mask_hit && !fault_log_clear // see (RULE_13)
    |=> $stable(wr_ptr_ff))
    else $error("masked fault logged");
  a_blk_reset: assert property (travel_done && !travel_fault_ff && !eff_fault |=> blk_cnt_ff == '0) // see (RULE_15)
    else $error("block counter not reset");
  a_fix_drop: assert property (s_fix_fault |=> s_dropped) // see (RULE_16)
    else $error("timed drop missing");
  a_lock_hold: assert property (locked_ff && lock_mode |=> locked_ff ##1 !malf_ff) // see (RULE_17)
    else $error("lock released");
  a_note_rep: assert property (eff_fault && nxt_consec > 8'h05 |=> note_stb_ff && note_code_ff == 10'h04D) // see (RULE_18)
    else $error("repeat note missing");
  a_ack_block: assert property (err_st_ff == ERR_ACK_WAIT && speed_preset_any && !eff_fault // see (RULE_21)
    |=> err_st_ff == ERR_ACTIVE)
    else $error("travel did not stop acknowledge");
endmodule

// [tb/dfd_ctl_model.sv]
// control system model: travel requests, speed presets and travel end
`timescale 1ns/1ps
module dfd_ctl_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic malfunction_output,
  input wire logic travel_req,
  output logic speed_preset_any,
  output logic drive_travel,
  output logic travel_done
);
  logic [3:0] run_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_ff <= 4'h0;
    end else if (travel_req) begin
      run_ff <= 4'h6;
    end else if (run_ff != 4'h0) begin
      run_ff <= run_ff - 4'h1;
    end
  end
  // presets removed as soon as the output drops
  assign speed_preset_any = (run_ff > 4'h1) && malfunction_output;
  assign drive_travel = run_ff != 4'h0;
  assign travel_done = run_ff == 4'h1;
endmodule

// [tb/dfd_top_tb.sv]
// self-checking bench for the drive fault diagnostics
`timescale 1ns/1ps
module dfd_top_tb;
  import dfd_pkg::*;
  logic clk, rst_b, drive_travel, link_enabled, link_ok, can_busoff, fault_evt, fault_cause_present;
  logic datetime_mode, speed_preset_any, travel_done, fault_log_clear, log_open, scroll_up, scroll_down;
  logic mains_interrupt_evt, enable_loss_abort_evt, contactor_abort_evt, evac_mode, sw_update_done, travel_req;
  logic led_red, led_green, malfunction_output, error_active, locked, note_stb;
  dfd_led_view_t led_view;
  dfd_can_state_t can_state;
  dfd_block_mode_t block_mode_select;
  logic [7:0] can_err_count;
  dfd_fault_t fault_rec;
  dfd_attr_t fault_attr;
  dfd_entry_t view_entry;
  logic [NUM_ERR_MASKS-1:0][ERR_W-1:0] err_mask;
  logic [ERR_W-1:0] neg_err_mask, note_code;
  logic [1:0] view_ofs;
  logic [2:0] log_count;
  logic [CNT_W-1:0] mains_interrupt_count, enable_loss_abort_count, contactor_abort_count;
  int num_errors, checked, cyc, rt, gt, i;

  dfd_top #(.ACK_CYC(8), .DROP_CYC(8), .TICK_CYC(4), .LOG_DEPTH_P(4)) DUT (.*);
  dfd_ctl_model ctl (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task fault(input logic [9:0] e, input logic [2:0] a);
    fault_rec.err_no = e;
    fault_attr = dfd_attr_t'(a);
    fault_evt = 1'b1;
    step(1);
    fault_evt = 1'b0;
    step(1);
  endtask
  task travel;
    travel_req = 1'b1;
    step(1);
    travel_req = 1'b0;
    step(10);
  endtask
  // counts colour changes over n cycles
  task toggles(input int n);
    logic r, g;
    step(2);
    r = led_red;
    g = led_green;
    rt = 0;
    gt = 0;
    repeat (n) begin
      step(1);
      if (led_red !== r) rt++;
      if (led_green !== g) gt++;
      r = led_red;
      g = led_green;
    end
  endtask
  task wait_note(input logic [9:0] code);
    int k;
    k = 0;
    step(1);
    while (note_stb !== 1'b1 && k < 6) begin
      step(1);
      k++;
    end
    check(note_stb, 1);
    check(note_code, code);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end

  initial begin
    {rst_b, link_enabled, link_ok, can_busoff, fault_evt, fault_cause_present, datetime_mode} = '0;
    {fault_log_clear, log_open, scroll_up, scroll_down, evac_mode, sw_update_done, travel_req} = '0;
    {mains_interrupt_evt, enable_loss_abort_evt, contactor_abort_evt} = '0;
    led_view = VIEW_CAN;
    can_state = CAN_OPERATIONAL;
    block_mode_select = BLK_FIX_2S;
    can_err_count = 8'h00;
    fault_rec = '0;
    fault_attr = '0;
    err_mask = '0;
    neg_err_mask = 10'h3FF;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    step(1);
    check(view_entry.rec.err_no, NOTE_EMPTY);
    can_busoff = 1'b1;
    step(3);
    check(led_red, 1);
    check(led_green, 1);
    can_busoff = 1'b0;
    step(3);
    check(led_red, 0);
    can_err_count = 8'h61;
    can_state = CAN_STOPPED;
    toggles(128);
    check(rt, 4);
    check(gt, 4);
    can_state = CAN_PREOP;
    toggles(128);
    check(gt, 32);
    led_view = VIEW_LINK;
    link_enabled = 1'b1;
    link_ok = 1'b1;
    step(3);
    check(led_green, 1);
    link_ok = 1'b0;
    toggles(128);
    check(rt, 32);
    link_enabled = 1'b0;
    link_ok = 1'b1;
    toggles(128);
    check(rt + gt, 4);
    led_view = VIEW_STANDARD;
    toggles(128);
    check(gt, 4);
    datetime_mode = 1'b1;
    fault_rec.date_time = 32'h0000ABCD;
    fault_rec.motor_current = 8'h3C;
    for (i = 1; i < 6; i++) fault(i[9:0], 3'h0);
    step(2);
    check(log_count, 4);
    check(view_entry.rec.err_no, 5);
    check(view_entry.rec.motor_current, 8'h3C);
    check(view_entry.rec.date_time, 32'h0000ABCD);
    repeat (4) begin
      scroll_up = 1'b1;
      step(1);
      scroll_up = 1'b0;
      step(2);
    end
    check(view_ofs, 3);
    check(view_entry.rec.err_no, 2);
    scroll_down = 1'b1;
    step(1);
    scroll_down = 1'b0;
    step(2);
    check(view_entry.rec.err_no, 3);
    err_mask[0] = 10'h007;
    neg_err_mask = 10'h008;
    fault(10'h007, 3'h4);
    fault(10'h00B, 3'h2);
    log_open = 1'b1;
    step(1);
    log_open = 1'b0;
    step(2);
    check(view_entry.rec.err_no, 5);
    fault(10'h008, 3'h2);
    step(2);
    check(view_entry.rec.err_no, 8);
    repeat (2) begin
      mains_interrupt_evt = 1'b1;
      step(1);
      mains_interrupt_evt = 1'b0;
      step(1);
    end
    {enable_loss_abort_evt, contactor_abort_evt} = 2'h3;
    step(1);
    {enable_loss_abort_evt, contactor_abort_evt} = 2'h0;
    step(2);
    check(mains_interrupt_count + enable_loss_abort_count + contactor_abort_count, 4);
    fault_log_clear = 1'b1;
    step(1);
    fault_log_clear = 1'b0;
    step(2);
    check({log_count, mains_interrupt_count}, 0);
    check({enable_loss_abort_count, contactor_abort_count}, 0);
    check(view_entry.rec.err_no, NOTE_EMPTY);
    step(40);
    fault(10'h00C, 3'h0);
    step(4);
    check(malfunction_output, 0);
    for (i = 0; i < 30 && (malfunction_output !== 1'b1 || error_active !== 1'b0); i++) step(1);
    check({malfunction_output, error_active}, 2);
    fault_cause_present = 1'b1;
    fault(10'h00E, 3'h0);
    step(12);
    fault_cause_present = 1'b0;
    step(3);
    travel;
    check(error_active, 1);
    step(6);
    check({malfunction_output, error_active}, 2);
    evac_mode = 1'b1;
    wait_note(NOTE_NORM_TO_EVA);
    evac_mode = 1'b0;
    wait_note(NOTE_EVA_TO_NORM);
    sw_update_done = 1'b1;
    wait_note(NOTE_SW_UPDATE);
    sw_update_done = 1'b0;
    repeat (5) fault(10'h009, 3'h0);
    fault_evt = 1'b1;
    wait_note(NOTE_REPEATED);
    fault_evt = 1'b0;
    step(1);
    check(view_entry.consec, 8'h06);
    block_mode_select = BLK_LOCK_2;
    step(40);
    fault(10'h00D, 3'h1);
    travel;
    travel;
    fault(10'h00D, 3'h1);
    step(2);
    check(locked, 0);
    travel;
    fault(10'h00D, 3'h1);
    step(2);
    check({locked, malfunction_output}, 2);
    stop_test;
  end
endmodule
